// File: cp_cfg.svh
// Constants for the serial control port in I2C mode: widths, reset values and settle counts.
// Summary of operation
// - Port is slave only, moves eight-bit bytes, never drives clock, only requests service.
// - Chip-select level sampled a few cycles after hardware or software reset; high selects I2C mode.
// - Request line low whenever the output byte register holds an unread byte, except one written from last bit rise to ack rise.
// - SDA is sampled on the rising edge of the master's serial clock.
// - Address check enable resets to zero; zero answers any address, one needs match.
// - Stored device address is loaded only from bytes received over the bus.
// - Write shifts 8 bits, loads input register at 8th falling edge, then acknowledges.
// - DSP write to output register asserts request; master answers with a read.
// - Read: ack address, then at ack falling edge load shifter and drive MSB.
// - Read data stays valid at rising edges and changes just after falling edges.
// - With no new byte, request releases after last bit rise until ack rise.
// - New byte before last bit rise keeps request low; loaded after ack fall.
// - Loaded byte shifts out on every clock despite STOP; master must read it.
// - Byte written between last bit rise and ack rise waits for a fresh read.
// - While boot download runs, the received address is ignored.
`ifndef CP_CFG_SVH
`define CP_CFG_SVH
`define CP_BYTE_BITS 8
`define CP_ADDR_BITS 7
`define CP_CNT_BITS 4
`define CP_LAST_BIT 4'h7
`define CP_IDLE_BYTE 8'hFF
`define CP_RST_CHECK_EN 1'b0
`define CP_RST_ADDR 7'h00
`define CP_STRAP_SETTLE 3'h4
`endif

// File: cp_evt.sv
// Turns a toggle from another clock domain into a one-cycle pulse.
module cp_evt (
    input wire logic clk,
    input wire logic rst,
    input wire logic tgl,
    output logic pulse
);
    logic tgl_s;
    logic seen_r;

    cp_sync3 #(.W(1)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(tgl),
        .q(tgl_s)
    );

    // Remember the last toggle level seen.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= tgl_s;
        end
    end

    assign pulse = tgl_s ^ seen_r;
endmodule : cp_evt

// File: cp_host_model.sv
// Behavioural I2C bus master that clocks the port and pulls SDA low when it sends a zero.
module cp_host_model (
    output logic scl,
    output logic pull,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 12;

    // The clock stands high between frames and only runs inside the tasks below.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end

    // START, or repeated START: SDA falls while the clock is high.
    task automatic start();
        #Q pull = 1'b0;
        #Q scl = 1'b1;
        #Q pull = 1'b1;
        #Q scl = 1'b0;
    endtask : start

    // STOP: SDA rises while the clock is high, then the bus is left released.
    task automatic stop();
        #Q pull = 1'b1;
        #Q scl = 1'b1;
        #Q pull = 1'b0;
        #Q;
    endtask : stop

    // One bit: data changes in the low phase, SDA is read at the rising edge.
    task automatic bit_xfer(input logic b, output logic r);
        #Q pull = ~b;
        #Q r = sda;
        scl = 1'b1;
        #(2 * Q) scl = 1'b0;
    endtask : bit_xfer

    // Address or data byte, MSB first; ack is high when the port pulled SDA in the ninth slot.
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : send

    // A refused data byte goes once more; a second miss is left in ack for the caller to check.
    task automatic send_again(input logic [7:0] d, output logic ack);
        send(d, ack);
        if (!ack) begin
            send(d, ack);
        end
    endtask : send_again

    // Reads a whole byte before doing anything else, since a loaded byte shifts on any clock.
    task automatic recv(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(~ack, r);
    endtask : recv
endmodule : cp_host_model

// File: cp_i2c_port.sv
// Serial control port, I2C mode: link logic on the serial clock, holding registers on the DSP clock.
`include "cp_cfg.svh"
module cp_i2c_port (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic boot_load,
    input wire logic cs_pin,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic req_n,
    input wire logic tx_wr,
    input wire logic [7:0] tx_data,
    input wire logic cfg_wr,
    input wire logic cfg_check_en,
    output cp_pkg::cp_port_cfg_t port_config_reg,
    output logic [7:0] host_to_dsp_byte_reg,
    output logic rx_irq,
    output logic tx_empty_irq,
    output logic tx_full,
    output logic i2c_mode,
    output logic bus_idle
);
    // ---------------- DSP clock domain state ----------------
    logic [7:0] dsp_to_host_byte_reg;
    logic blk_r;
    logic strap_pend_r;
    logic [2:0] strap_cnt_r;
    logic cs_s;
    logic [1:0] pins_s;
    logic rx_evt;
    logic ld_evt;
    logic last_evt;
    logic ackr_evt;

    // ---------------- Serial clock domain state ----------------
    cp_pkg::cp_link_state_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] rx_hold_r;
    logic rx_tgl_r;
    logic ld_tgl_r;
    logic sda_rise_r;
    cp_pkg::cp_last_t last_r;
    logic ackr_tgl_r;
    logic start_tgl_r;
    logic stop_tgl_r;
    logic start_seen_r;
    logic stop_seen_r;
    logic full_s;
    logic [7:0] tx_s;
    cp_pkg::cp_port_cfg_t cfg_s;
    logic mode_s;
    logic boot_s;
    logic [7:0] in_byte;
    logic [7:0] ld_byte;
    logic addr_hit;
    logic start_now;
    logic stop_now;

    // ======================= DSP side =======================

    // Chip-select and bus pins enter through the three-stage filter.
    cp_sync3 #(.W(1)) u_cs_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d(cs_pin),
        .q(cs_s)
    );

    cp_sync3 #(.W(2)) u_pin_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .d({scl_clk, sda_i}),
        .q(pins_s)
    );

    // Events from the link arrive as toggles.
    cp_evt u_rx_evt (
        .clk(ref_clk),
        .rst(sys_rst),
        .tgl(rx_tgl_r),
        .pulse(rx_evt)
    );

    cp_evt u_ld_evt (
        .clk(ref_clk),
        .rst(sys_rst),
        .tgl(ld_tgl_r),
        .pulse(ld_evt)
    );

    cp_evt u_last_evt (
        .clk(ref_clk),
        .rst(sys_rst),
        .tgl(last_r.tgl),
        .pulse(last_evt)
    );

    cp_evt u_ackr_evt (
        .clk(ref_clk),
        .rst(sys_rst),
        .tgl(ackr_tgl_r),
        .pulse(ackr_evt)
    );

    // The strap is caught a few cycles after either reset, once the filter has settled.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_pend_r <= 1'b1;
            strap_cnt_r <= 3'h0;
            i2c_mode <= 1'b0;
        end else if (soft_rst) begin
            strap_pend_r <= 1'b1;
            strap_cnt_r <= 3'h0;
        end else if (strap_pend_r) begin
            if (strap_cnt_r == `CP_STRAP_SETTLE) begin
                i2c_mode <= cs_s;
                strap_pend_r <= 1'b0;
            end else begin
                strap_cnt_r <= strap_cnt_r + 3'h1;
            end
        end
    end

    // Configuration clears on any reset, so the port first answers every address.
    // The address field comes only from the last byte the master sent.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_config_reg.address_check_enable <= `CP_RST_CHECK_EN;
            port_config_reg.addr <= `CP_RST_ADDR;
        end else if (soft_rst) begin
            port_config_reg.address_check_enable <= `CP_RST_CHECK_EN;
            port_config_reg.addr <= `CP_RST_ADDR;
        end else if (cfg_wr) begin
            port_config_reg.address_check_enable <= cfg_check_en;
            port_config_reg.addr <= host_to_dsp_byte_reg[6:0];
        end
    end

    // Input holding register and its arrival pulse.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_to_dsp_byte_reg <= 8'h00;
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= rx_evt;
            if (rx_evt) begin
                host_to_dsp_byte_reg <= rx_hold_r;
            end
        end
    end

    // Output holding register. A write while full is dropped so that the word the
    // link may be copying never changes under it.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dsp_to_host_byte_reg <= 8'h00;
            tx_full <= 1'b0;
            tx_empty_irq <= 1'b0;
        end else if (soft_rst) begin
            tx_full <= 1'b0;
            tx_empty_irq <= 1'b0;
        end else begin
            tx_empty_irq <= ld_evt;
            if (tx_wr && !tx_full) begin
                dsp_to_host_byte_reg <= tx_data;
                tx_full <= 1'b1;
            end else if (ld_evt) begin
                tx_full <= 1'b0;
            end
        end
    end

    // After a last data bit with nothing queued, the request stays released until
    // the acknowledge rise even if the DSP refills meanwhile.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            blk_r <= 1'b0;
        end else if (ackr_evt) begin
            blk_r <= 1'b0;
        end else if (last_evt && !last_r.more) begin
            blk_r <= 1'b1;
        end
    end

    // Request pin, active low, registered.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_n <= 1'b1;
        end else begin
            req_n <= !(i2c_mode && tx_full && !blk_r);
        end
    end

    // Bus seen idle when both lines settle high.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_idle <= 1'b0;
        end else begin
            bus_idle <= &pins_s;
        end
    end

    // ======================= Link side =======================

    // Levels from the DSP side reach the serial clock domain. The byte word is
    // read only while its full flag has settled, so it never moves under the link.
    cp_sync3 #(.W(1)) u_full_sync (
        .clk(scl_clk),
        .rst(sys_rst),
        .d(tx_full),
        .q(full_s)
    );

    cp_sync3 #(.W(8)) u_tx_sync (
        .clk(scl_clk),
        .rst(sys_rst),
        .d(dsp_to_host_byte_reg),
        .q(tx_s)
    );

    cp_sync3 #(.W(10)) u_cfg_sync (
        .clk(scl_clk),
        .rst(sys_rst),
        .d({port_config_reg, i2c_mode, boot_load}),
        .q({cfg_s, mode_s, boot_s})
    );

    // START is SDA falling and STOP is SDA rising while SCL is high. The serial
    // clock stands still around them, so SDA itself marks them; each edge only flips
    // a toggle that the clock logic compares at its next falling edge.
    always_ff @(negedge sda_i or posedge sys_rst) begin
        if (sys_rst) begin
            start_tgl_r <= 1'b0;
        end else if (scl_clk) begin
            start_tgl_r <= !start_tgl_r;
        end
    end

    always_ff @(posedge sda_i or posedge sys_rst) begin
        if (sys_rst) begin
            stop_tgl_r <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl_r <= !stop_tgl_r;
        end
    end

    assign start_now = start_tgl_r ^ start_seen_r;
    assign stop_now = stop_tgl_r ^ stop_seen_r;
    assign in_byte = {sh_r[6:0], sda_rise_r};
    assign ld_byte = full_s ? tx_s : `CP_IDLE_BYTE;
    assign addr_hit = !cfg_s.address_check_enable || boot_s || (in_byte[7:1] == cfg_s.addr);

    // Rising edge: sample SDA, report the last read bit and the acknowledge rise.
    always_ff @(posedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_rise_r <= 1'b1;
            last_r <= '0;
            ackr_tgl_r <= 1'b0;
        end else begin
            sda_rise_r <= sda_i;
            if (st_r == cp_pkg::CP_RD && cnt_r == `CP_LAST_BIT) begin
                last_r.tgl <= !last_r.tgl;
                last_r.more <= full_s;
            end
            if (st_r == cp_pkg::CP_RACK) begin
                ackr_tgl_r <= !ackr_tgl_r;
            end
        end
    end

    // Falling edge: sequencing, shifting and SDA drive. All SDA changes happen
    // here, so data is steady through every rising edge.
    always_ff @(negedge scl_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= cp_pkg::CP_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rx_hold_r <= 8'h00;
            rx_tgl_r <= 1'b0;
            ld_tgl_r <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
        end else begin
            start_seen_r <= start_tgl_r;
            stop_seen_r <= stop_tgl_r;
            sda_o <= 1'b0; // Open drain: only ever pulls low.
            if (start_now) begin
                st_r <= cp_pkg::CP_ADDR;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_now && st_r != cp_pkg::CP_RD && st_r != cp_pkg::CP_RACK) begin
                st_r <= cp_pkg::CP_IDLE; // A loaded read byte keeps shifting.
                sda_oe <= 1'b0;
            end else begin
                unique case (st_r)
                    cp_pkg::CP_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    cp_pkg::CP_ADDR: begin
                        sh_r <= in_byte;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `CP_LAST_BIT) begin
                            if (mode_s && addr_hit) begin
                                sda_oe <= 1'b1;
                                st_r <= cp_pkg::CP_AACK;
                            end else begin
                                st_r <= cp_pkg::CP_IDLE;
                            end
                        end
                    end
                    cp_pkg::CP_AACK: begin
                        cnt_r <= 4'h0;
                        if (sh_r[0]) begin
                            sh_r <= ld_byte;
                            sda_oe <= !ld_byte[7];
                            ld_tgl_r <= ld_tgl_r ^ full_s;
                            st_r <= cp_pkg::CP_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            st_r <= cp_pkg::CP_WR;
                        end
                    end
                    cp_pkg::CP_WR: begin
                        sh_r <= in_byte;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == `CP_LAST_BIT) begin
                            rx_hold_r <= in_byte;
                            rx_tgl_r <= !rx_tgl_r;
                            sda_oe <= 1'b1;
                            st_r <= cp_pkg::CP_WACK;
                        end
                    end
                    cp_pkg::CP_WACK: begin
                        sda_oe <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r <= cp_pkg::CP_WR;
                    end
                    cp_pkg::CP_RD: begin
                        if (cnt_r == `CP_LAST_BIT) begin
                            sda_oe <= 1'b0;
                            st_r <= cp_pkg::CP_RACK;
                        end else begin
                            sh_r <= {sh_r[6:0], 1'b0};
                            sda_oe <= !sh_r[6];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    cp_pkg::CP_RACK: begin
                        cnt_r <= 4'h0;
                        if (!sda_rise_r && last_r.more && full_s) begin
                            sh_r <= tx_s;
                            sda_oe <= !tx_s[7];
                            ld_tgl_r <= !ld_tgl_r;
                            st_r <= cp_pkg::CP_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            st_r <= cp_pkg::CP_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule : cp_i2c_port

// File: cp_i2c_port_bench.sv
// Self-checking bench for the I2C control port with a behavioural bus master.
module cp_i2c_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, sys_rst, soft_rst, boot_load, cs_pin, scl_clk, sda_i, sda_o, sda_oe, req_n;
    logic tx_wr, cfg_wr, cfg_check_en, rx_irq, tx_empty_irq, tx_full, i2c_mode, bus_idle, host_pull, ack;
    logic [7:0] tx_data, h2d, got;
    cp_pkg::cp_port_cfg_t cfg;
    int n_mismatch = 0;
    int check_count = 0;

    // Open-drain SDA with a pull-up: low whenever either side pulls it.
    assign sda_i = ~(sda_oe | host_pull);

    cp_i2c_port i_cp_i2c_port (
        .ref_clk, .sys_rst, .soft_rst, .boot_load, .cs_pin, .scl_clk, .sda_i, .sda_o, .sda_oe, .req_n,
        .tx_wr, .tx_data, .cfg_wr, .cfg_check_en, .port_config_reg(cfg), .host_to_dsp_byte_reg(h2d),
        .rx_irq, .tx_empty_irq, .tx_full, .i2c_mode, .bus_idle
    );
    cp_host_model i_cp_host_model (.scl(scl_clk), .pull(host_pull), .sda(sda_i));

    // DSP clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk1

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // One write strobe into the output byte register.
    task automatic dsp_put(input logic [7:0] d);
        @(negedge ref_clk);
        tx_data = d;
        tx_wr = 1'b1;
        @(negedge ref_clk);
        tx_wr = 1'b0;
    endtask : dsp_put

    // Software reset pulse, then time for the strap to settle.
    task automatic soft_pulse();
        cyc(2);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        cyc(12);
    endtask : soft_pulse

    // Addresses the port and closes the frame at once; ack keeps the answer.
    task automatic probe(input logic [7:0] a);
        @(negedge ref_clk);
        i_cp_host_model.start();
        i_cp_host_model.send(a, ack);
        i_cp_host_model.stop();
        cyc(4);
    endtask : probe

    task automatic t_reset();
        chk1(req_n, 1'b1);
        chk1(tx_full, 1'b0);
        chk8(cfg, 8'h00);
        chk1(i2c_mode, 1'b1);
        chk1(bus_idle, 1'b1);
        chk1(sda_oe, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        @(negedge ref_clk);
        i_cp_host_model.start();
        i_cp_host_model.send(8'h54, ack);
        chk1(ack, 1'b1);
        fork
            begin
                i_cp_host_model.send_again(8'hA5, ack);
                i_cp_host_model.stop();
            end
            begin
                for (int i = 0; i < 60 && rx_irq !== 1'b1; i++) begin
                    @(negedge ref_clk);
                end
                chk1(rx_irq, 1'b1);
            end
        join
        chk1(ack, 1'b1);
        cyc(8);
        chk8(h2d, 8'hA5);
        chk1(sda_o, 1'b0);
        $display("test write done");
    endtask : t_write

    // The stored address comes from a received byte; strangers are then refused except during boot.
    task automatic t_addr();
        @(negedge ref_clk);
        i_cp_host_model.start();
        i_cp_host_model.send(8'h24, ack);
        i_cp_host_model.send(8'h35, ack);
        i_cp_host_model.stop();
        cyc(8);
        cfg_check_en = 1'b1;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
        chk8(cfg, 8'hB5);
        probe(8'h24);
        chk1(ack, 1'b0);
        probe(8'h6A);
        chk1(ack, 1'b1);
        boot_load = 1'b1;
        probe(8'h24);
        chk1(ack, 1'b1);
        boot_load = 1'b0;
        $display("test address done");
    endtask : t_addr

    task automatic t_mode();
        cs_pin = 1'b0;
        soft_pulse();
        chk1(i2c_mode, 1'b0);
        chk8(cfg, 8'h00);
        probe(8'h24);
        chk1(ack, 1'b0);
        cs_pin = 1'b1;
        soft_pulse();
        chk1(i2c_mode, 1'b1);
        $display("test mode done");
    endtask : t_mode

    // Single read; a second DSP write while full must be dropped.
    task automatic t_read();
        dsp_put(8'hC3);
        dsp_put(8'h11);
        chk1(req_n, 1'b0);
        @(negedge ref_clk);
        i_cp_host_model.start();
        i_cp_host_model.send(8'h25, ack);
        chk1(ack, 1'b1);
        i_cp_host_model.recv(1'b0, got);
        chk8(got, 8'hC3);
        i_cp_host_model.stop();
        cyc(8);
        chk1(req_n, 1'b1);
        chk1(tx_full, 1'b0);
        $display("test read done");
    endtask : t_read

    // A byte queued in mid-read follows straight on without a new address.
    task automatic t_queue();
        dsp_put(8'h5A);
        @(negedge ref_clk);
        i_cp_host_model.start();
        i_cp_host_model.send(8'h25, ack);
        fork
            i_cp_host_model.recv(1'b1, got);
            begin
                for (int i = 0; i < 60 && tx_empty_irq !== 1'b1; i++) begin
                    @(negedge ref_clk);
                end
                chk1(tx_empty_irq, 1'b1);
                dsp_put(8'h96);
            end
        join
        chk8(got, 8'h5A);
        chk1(req_n, 1'b0);
        i_cp_host_model.recv(1'b0, got);
        chk8(got, 8'h96);
        i_cp_host_model.stop();
        cyc(8);
        chk1(req_n, 1'b1);
        $display("test queue done");
    endtask : t_queue

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // The port stays in reset until the master is ready, with the strap high for I2C.
    initial begin
        sys_rst = 1'b1;
        soft_rst = 1'b0;
        boot_load = 1'b0;
        cs_pin = 1'b1;
        tx_wr = 1'b0;
        tx_data = 8'h00;
        cfg_wr = 1'b0;
        cfg_check_en = 1'b0;
        cyc(6);
        sys_rst = 1'b0;
        cyc(12);
        t_reset();
        t_write();
        t_addr();
        t_mode();
        t_read();
        t_queue();
        tally_and_finish();
    end

    // The tests need well under 20 microseconds; a hang is cut off far beyond that.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : cp_i2c_port_bench

// File: cp_i2c_port_monitor.sv
// Checker for the I2C control port: request line, holding registers, strap and SDA drive timing.
module cp_i2c_port_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic cs_pin,
    input wire logic scl_clk,
    input wire logic sda_oe,
    input wire logic req_n,
    input wire logic tx_wr,
    input wire logic cfg_wr,
    input wire logic cfg_check_en,
    input wire cp_pkg::cp_port_cfg_t port_config_reg,
    input wire logic [7:0] host_to_dsp_byte_reg,
    input wire logic rx_irq,
    input wire logic tx_full,
    input wire logic i2c_mode,
    input wire logic bus_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] since_rst_r;

    // Edges since the last reset; it saturates so the strap is only judged close to a reset.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            since_rst_r <= 4'h0;
        end else if (soft_rst) begin
            since_rst_r <= 4'h0;
        end else if (since_rst_r != 4'hF) begin
            since_rst_r <= since_rst_r + 4'h1;
        end
    end

    // Idle for longer than one clock-high phase, so a frame in progress cannot pass for quiet.
    sequence s_quiet;
        bus_idle [*4];
    endsequence

    property p_sda_hold;
        @(posedge ref_clk) disable iff (sys_rst) scl_clk && $past(scl_clk) |-> $stable(sda_oe);
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("SDA drive moved while SCL high");

    property p_full_set;
        @(posedge ref_clk) disable iff (sys_rst) tx_wr && !tx_full |=> tx_full;
    endproperty
    a_full_set: assert property (p_full_set) else $error("output byte not marked full");

    property p_req_on;
        @(posedge ref_clk) disable iff (sys_rst) s_quiet ##0 ($rose(tx_full) && i2c_mode) |=> !req_n;
    endproperty
    a_req_on: assert property (p_req_on) else $error("request not raised after DSP write");

    property p_req_off;
        @(posedge ref_clk) disable iff (sys_rst) !tx_full && !$past(tx_full) |-> req_n;
    endproperty
    a_req_off: assert property (p_req_off) else $error("request low with nothing to send");

    property p_rx;
        @(posedge ref_clk) disable iff (sys_rst) $changed(host_to_dsp_byte_reg) |-> ##[0:1] rx_irq;
    endproperty
    a_rx: assert property (p_rx) else $error("received byte without its pulse");

    property p_strap;
        @(posedge ref_clk) disable iff (sys_rst)
            ($changed(i2c_mode) |-> since_rst_r <= 4'h7) and (since_rst_r == 4'h8 |-> i2c_mode == cs_pin);
    endproperty
    a_strap: assert property (p_strap) else $error("mode strap latched wrongly");

    property p_no_drive;
        @(posedge scl_clk) disable iff (sys_rst) !i2c_mode |-> !sda_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) else $error("SDA pulled outside I2C mode");

    property p_cfg;
        @(posedge ref_clk) disable iff (sys_rst)
            cfg_wr |=> port_config_reg.address_check_enable == $past(cfg_check_en)
                && {1'b0, port_config_reg.addr} == ($past(host_to_dsp_byte_reg) & 8'h7F);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config not taken from last byte");
endmodule : cp_i2c_port_monitor

bind cp_i2c_port cp_i2c_port_monitor i_cp_i2c_port_monitor (
    .ref_clk, .sys_rst, .soft_rst, .cs_pin, .scl_clk, .sda_oe, .req_n, .tx_wr, .cfg_wr, .cfg_check_en,
    .port_config_reg, .host_to_dsp_byte_reg, .rx_irq, .tx_full, .i2c_mode, .bus_idle
);

// File: cp_pkg.sv
// Types shared by the serial control port modules.
package cp_pkg;
    // Link-side sequencing, one-hot.
    typedef enum logic [6:0] {
        CP_IDLE = 7'h01,
        CP_ADDR = 7'h02,
        CP_AACK = 7'h04,
        CP_WR = 7'h08,
        CP_WACK = 7'h10,
        CP_RD = 7'h20,
        CP_RACK = 7'h40
    } cp_link_state_t;

    // Port configuration register contents.
    typedef struct packed {
        logic address_check_enable;
        logic [6:0] addr;
    } cp_port_cfg_t;

    // Read-side end-of-byte report: the toggle plus whether a new byte followed.
    typedef struct packed {
        logic tgl;
        logic more;
    } cp_last_t;
endpackage : cp_pkg

// File: cp_sync3.sv
// Three-stage synchronizer that passes a change once the second and third stages agree.
module cp_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Output follows only a settled value.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end
endmodule : cp_sync3
